// >>> dv/iprs_core.sv
// core side model: pending sources and handler state
`timescale 1ns/100ps
module iprs_core(input wire clk_sys,output reg [6:0] irq_pending=0,output reg in_low_handler=0,in_high_handler=0);
// nested handlers allowed, a high one may sit on a low one
always @(posedge clk_sys){irq_pending,in_low_handler,in_high_handler}<=#1 {irq_pending,in_low_handler,in_high_handler}+9'h0B5;
endmodule // iprs_core

// >>> dv/iprs_monitor.sv
// checker on the priority register ports
`timescale 1ns/100ps
module iprs_monitor(input wire clk_sys,rstn,sfr_wr,sfr_bit_wr,sfr_bit_val,sfr_rd,sfr_rvalid,high_req,low_req,
input wire take_irq,in_low_handler,in_high_handler,
input wire [7:0] sfr_addr,sfr_wdata,sfr_rdata,input wire [2:0] sfr_bit_sel,input wire [6:0] irq_pending,src_priority);
wire h=sfr_addr==8'hB8;
default clocking @(posedge clk_sys);endclocking
default disable iff(!rstn);
byte_wr_a:assert property(h&&sfr_wr|=>src_priority==$past(sfr_wdata[6:0]))else $error("wr");
bit_wr_a:assert property(h&&sfr_bit_wr&&!sfr_wr&&sfr_bit_sel<7|=>src_priority[$past(sfr_bit_sel)]==$past(sfr_bit_val))else $error("bit");
prio_hold_a:assert property(!(h&&(sfr_wr||sfr_bit_wr&&sfr_bit_sel<7))|=>$stable(src_priority))else $error("hold");
rd_data_a:assert property(h&&sfr_rd|=>sfr_rvalid&&sfr_rdata=={1'b1,$past(src_priority)})else $error("rd");
hi_req_a:assert property(1|=>high_req==$past(|(irq_pending&src_priority)))else $error("hi");
lo_req_a:assert property(1|=>low_req==$past(|(irq_pending&~src_priority)))else $error("lo");
take_arb_a:assert property(1|=>take_irq==$past((|(irq_pending&src_priority)&&!in_high_handler)||(|(irq_pending&~src_priority)&&!in_high_handler&&!in_low_handler)))else $error("take");
rvalid_pulse_a:assert property(!(h&&sfr_rd)|=>!sfr_rvalid)else $error("rvalid");
cover property(take_irq&&in_low_handler);
cover property(h&&sfr_bit_wr);cover property(high_req&&low_req);cover property(sfr_rvalid&&sfr_rdata!=8'h80);
endmodule // iprs_monitor
bind iprs_priority_reg iprs_monitor i_iprs_monitor(.*);

// >>> dv/iprs_priority_reg_tb.sv
// bench comparing the priority register with a reference model
`timescale 1ns/100ps
module iprs_priority_reg_tb;
reg clk_sys=0,rstn=0,sfr_wr=0,sfr_bit_wr=0,sfr_bit_val=0,sfr_rd=0;reg [7:0] sfr_addr=0,sfr_wdata=0;reg [2:0] sfr_bit_sel=0;
wire [7:0] sfr_rdata;wire sfr_rvalid,in_low_handler,in_high_handler,high_req,low_req,take_irq;
wire [6:0] src_priority,irq_pending;reg [6:0] m=0;
integer error_cnt=0,checks_done=0,i,seed=32'h0BA70A4E;
always #50 clk_sys=~clk_sys;
iprs_core i_iprs_core(.*);
iprs_priority_reg i_iprs_priority_reg(.*);
task chk(input [7:0] x,e);begin checks_done=checks_done+1;if(x!==e)begin error_cnt=error_cnt+1;
$display("unexpected at %0t: %h not %h",$time,x,e);end end endtask
task print_verdict;begin $display("checks %0d errors %0d",checks_done,error_cnt);
if(error_cnt==0&&checks_done>0)$display("TEST PASSED");else $display("TEST FAILED");$finish;end endtask
// byte write beats bit write; a read in a write cycle sees the old value
task op(input [22:0] c);reg [7:0] e;reg h;reg [6:0] p;reg lh,hh;begin e={1'b1,m};h=c[22:15]==8'hB8;
{sfr_addr,sfr_wr,sfr_bit_wr,sfr_bit_sel,sfr_bit_val,sfr_wdata,sfr_rd}=c;
if(h&&c[14])m=c[7:1];else if(h&&c[13]&&c[12:10]<7)m[c[12:10]]=c[9];
@(posedge clk_sys);p=irq_pending;lh=in_low_handler;hh=in_high_handler;#1;
chk(src_priority,{1'b0,m});chk(sfr_rvalid,h&&c[0]);if(h&&c[0])chk(sfr_rdata,e);
chk(high_req,|(p&e[6:0]));chk(low_req,|(p&~e[6:0]));
chk(take_irq,(|(p&e[6:0])&&!hh)||(|(p&~e[6:0])&&!hh&&!lh));end endtask
initial begin repeat(12)@(posedge clk_sys);#1 rstn=1;
op(23'h5C0001);$display("reset test done");
for(i=0;i<8;i=i+1)op(23'h5C2201|23'(i<<10));
$display("bit test done");
for(i=0;i<300;i=i+1)op({i[0]?8'hB8:8'($random(seed)),15'($random(seed))});
op(0);$display("random done");
rstn=0;m=0;repeat(2)@(posedge clk_sys);#1 rstn=1;
op(23'h5C0001);$display("second reset done");
print_verdict;end
endmodule // iprs_priority_reg_tb

// >>> rtl/iprs_defs.vh
// constants for the interrupt priority select register
`ifndef IPRS_DEFS_VH
`define IPRS_DEFS_VH
`define IPRS_SFR_ADDR        8'hB8
`define IPRS_RESET_VAL       8'h80
`define IPRS_PRIO_RESET      7'h00
`define IPRS_WR_MASK         8'h7F
`define IPRS_BIT_UNUSED      3'h7
`define IPRS_BIT_SPI         3'h6
`define IPRS_BIT_T2          3'h5
`define IPRS_BIT_UART        3'h4
`define IPRS_BIT_T1          3'h3
`define IPRS_BIT_X1          3'h2
`define IPRS_BIT_T0          3'h1
`define IPRS_BIT_X0          3'h0
`define IPRS_NUM_SRC         7
`endif

// >>> rtl/iprs_priority_reg.v
// interrupt priority select register with priority arbitration helper
`timescale 1ns/100ps
// Summary of operation
// - register sits at sfr address B8h; byte and single-bit writes supported
// - bit 7 always reads one; writes to it are ignored
// - bit 6 sets serial peripheral port priority, 1 means high
// - bit 5 sets timer 2 priority, 1 means high
// - bit 4 sets asynchronous serial port priority, 1 means high
// - bit 3 sets timer 1 priority, 1 means high
// - bit 2 sets external interrupt 1 priority, 1 means high
// - bit 1 sets timer 0 priority, 1 means high
// - bit 0 sets external interrupt 0 priority, 1 means high
`include "iprs_defs.vh"

module iprs_priority_reg
(
    input  wire       clk_sys,
    input  wire       rstn,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire       sfr_bit_wr,
    input  wire [2:0] sfr_bit_sel,
    input  wire       sfr_bit_val,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd,
    input  wire [6:0] irq_pending,
    input  wire       in_low_handler,
    input  wire       in_high_handler,
    output reg  [7:0] sfr_rdata,
    output reg        sfr_rvalid,
    output reg  [6:0] src_priority,
    output reg        high_req,
    output reg        low_req,
    output reg        take_irq
);

    //**************************************************
    // local helpers
    //**************************************************

    // one address decode shared by write, bit-write and read paths
    function addr_match;
        input [7:0] addr;
        begin
            addr_match = (addr == `IPRS_SFR_ADDR);
        end
    endfunction

    // merge one written bit into the stored priority word
    function [6:0] merge_bit;
        input [6:0] cur;
        input [2:0] sel;
        input       val;
        begin
            merge_bit = cur;
            // bit 7 has no storage, so its writes fall away here
            if (sel != `IPRS_BIT_UNUSED)
                merge_bit[sel] = val;
        end
    endfunction

    // true when any pending source sits at the asked level
    function any_at_level;
        input [6:0] pend;
        input [6:0] prio;
        input       level;
        begin
            if (level)
                any_at_level = |(pend & prio);
            else
                any_at_level = |(pend & ~prio);
        end
    endfunction

    //**************************************************
    // register storage
    //**************************************************
    reg  [6:0] prio_q;
    reg  [6:0] prio_d;
    wire       hit;
    wire       byte_wr_hit;
    wire       bit_wr_hit;
    wire       rd_hit;
    wire       hi_any;
    wire       lo_any;
    wire       take_d;

    // named views of the stored bits
    wire       serial_port_priority_bit;
    wire       timer2_priority_bit;
    wire       async_serial0_priority_bit;
    wire       timer1_priority_bit;
    wire       ext_int1_priority_bit;
    wire       timer0_priority_bit;
    wire       ext_int0_priority_bit;

    //**************************************************
    // access decode
    //**************************************************

    assign hit         = addr_match(sfr_addr);

    assign byte_wr_hit = hit && sfr_wr;

    assign bit_wr_hit  = hit && sfr_bit_wr;

    // read strobe, registered below
    assign rd_hit      = hit && sfr_rd;

    //**************************************************
    // priority word update
    //**************************************************

    // byte write wins over a bit write in the same cycle
    always @*
    begin
        prio_d = prio_q;
        if (byte_wr_hit)
        begin
            // bit 7 of the written byte is dropped
            prio_d = sfr_wdata[6:0];
        end
        else if (bit_wr_hit)
        begin
            prio_d = merge_bit(prio_q, sfr_bit_sel, sfr_bit_val);
        end
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            prio_q <= `IPRS_PRIO_RESET;
        else
            prio_q <= prio_d;
    end

    //**************************************************
    // per-source priority bits
    //**************************************************

    assign serial_port_priority_bit   = prio_q[`IPRS_BIT_SPI];

    assign timer2_priority_bit        = prio_q[`IPRS_BIT_T2];

    assign async_serial0_priority_bit = prio_q[`IPRS_BIT_UART];

    assign timer1_priority_bit        = prio_q[`IPRS_BIT_T1];

    assign ext_int1_priority_bit      = prio_q[`IPRS_BIT_X1];

    assign timer0_priority_bit        = prio_q[`IPRS_BIT_T0];

    assign ext_int0_priority_bit      = prio_q[`IPRS_BIT_X0];

    //**************************************************
    // arbitration helper
    //**************************************************

    assign hi_any = any_at_level(irq_pending, prio_q, 1'b1);
    assign lo_any = any_at_level(irq_pending, prio_q, 1'b0);

    // low cannot interrupt any handler; high only interrupts a low one
    assign take_d = (hi_any && !in_high_handler) ||
                    (lo_any && !in_high_handler && !in_low_handler);

    //**************************************************
    // read path
    //**************************************************

    // read data holds until the next read, so the core may sample late
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            sfr_rdata <= `IPRS_RESET_VAL;
        end
        else if (rd_hit)
        begin
            sfr_rdata <= {1'b1,
                          serial_port_priority_bit,
                          timer2_priority_bit,
                          async_serial0_priority_bit,
                          timer1_priority_bit,
                          ext_int1_priority_bit,
                          timer0_priority_bit,
                          ext_int0_priority_bit};
        end
    end

    // one-cycle read strobe
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            sfr_rvalid <= 1'b0;
        else
            sfr_rvalid <= rd_hit;
    end

    //**************************************************
    // outputs to the core
    //**************************************************

    // per-source level
    // taken from the next value so it tracks the stored word exactly
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            src_priority <= `IPRS_PRIO_RESET;
        else
            src_priority <= prio_d;
    end

    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            high_req <= 1'b0;
            low_req  <= 1'b0;
        end
        else
        begin
            high_req <= hi_any;
            low_req  <= lo_any;
        end
    end

    // permission to take an interrupt, one cycle behind its inputs
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            take_irq <= 1'b0;
        else
            take_irq <= take_d;
    end

endmodule // iprs_priority_reg
